// ===== design/dcs_reg_bank.v
`timescale 1ns/10ps
`default_nettype none
`include "dcs_consts.vh"
// ----------------------------------------------------------------
// Two-wire target holding eight system registers
// ----------------------------------------------------------------
module dcs_reg_bank (
  input  wire       sys_clk,
  input  wire       srst,
  input  wire       scl_in,
  input  wire       sda_in,
  output reg        sda_out,
  output reg        sda_oe,
  input  wire       power_good,
  input  wire       over_temp_in,
  input  wire [1:0] open_cable_in,
  input  wire [1:0] voltage_range_in,
  input  wire [1:0] overcurrent_in,
  input  wire [1:0] back_current_in,
  input  wire [1:0] range_pin_in,
  input  wire [1:0] modulation_in,
  output reg  [1:0] tone_on,
  output reg  [1:0] tone_passthrough,
  output reg  [1:0] detect_tx_threshold,
  output reg  [1:0] dynamic_limit,
  output reg  [5:0] limit_code,
  output reg  [1:0] power_enable,
  output reg  [3:0] level_code
);
  // ----------------------------------------------------------------
  // Link sampling
  // ----------------------------------------------------------------
  localparam ST_IDLE = 3'h0;
  localparam ST_ADDR = 3'h1;
  localparam ST_AACK = 3'h2;
  localparam ST_WDAT = 3'h3;
  localparam ST_WACK = 3'h4;
  localparam ST_RDAT = 3'h5;
  localparam ST_RACK = 3'h6;

  wire [5:0] pins_in;
  wire [5:0] pins;
  assign pins_in = {range_pin_in, modulation_in, scl_in, sda_in};

  dcs_pin_sync #(
    .WIDTH (6)
  ) u_sync (
    .sys_clk (sys_clk),
    .srst    (srst),
    .pin_in  (pins_in),
    .pin_out (pins)
  );

  wire       scl = pins[1];
  wire       sda = pins[0];
  wire [1:0] mod_s = pins[3:2];
  wire [1:0] rng_s = pins[5:4];

  reg        scl_d;
  reg        sda_d;
  reg  [2:0] state;
  reg  [3:0] bit_cnt;
  reg  [7:0] shift;
  reg  [2:0] rd_ptr;
  reg  [7:0] regs [0:7];
  reg  [2:0] pg_sync;
  reg        pg;

  wire scl_rise = scl & ~scl_d;
  wire scl_fall = ~scl & scl_d;
  wire start_c  = scl & scl_d & sda_d & ~sda;
  wire stop_c   = scl & scl_d & ~sda_d & sda;

  // ----------------------------------------------------------------
  // Register image with live flags in the status registers
  // ----------------------------------------------------------------
  wire [7:0] rd_word [0:7];
  genvar g;
  generate
    for (g = 0; g < 8; g = g + 1) begin : g_rd
      if (g == 0) begin : g_s1
        assign rd_word[g] = {regs[g][7:5], over_temp_in, open_cable_in[0],
                             voltage_range_in[0], overcurrent_in[0],
                             back_current_in[0]};
      end else if (g == 4) begin : g_s2
        assign rd_word[g] = {regs[g][7:5], 1'b0, open_cable_in[1],
                             voltage_range_in[1], overcurrent_in[1],
                             back_current_in[1]};
      end else begin : g_rw
        assign rd_word[g] = regs[g];
      end
    end
  endgenerate

  // Per-register writable bits; flags and unused bits keep zero
  function [7:0] wmask;
    input [1:0] kind;
    begin
      case (kind)
        2'h0:    wmask = `DCS_STATUS_WMASK;
        2'h1:    wmask = `DCS_TONE_WMASK;
        2'h2:    wmask = `DCS_LIMIT_WMASK;
        default: wmask = `DCS_OUTPUT_WMASK;
      endcase
    end
  endfunction

  wire [2:0] wsel = shift[`DCS_SEL_MSB:`DCS_SEL_LSB];

  // Power-good is asynchronous; taken once stages 2 and 3 agree
  always @(posedge sys_clk) begin
    if (srst) begin
      pg_sync <= 3'h0;
      pg      <= 1'b0;
    end else begin
      pg_sync <= {pg_sync[1:0], power_good};
      if (pg_sync[1] == pg_sync[2])
        pg <= pg_sync[2];
    end
  end

  // ----------------------------------------------------------------
  // Protocol engine
  // ----------------------------------------------------------------
  integer i;
  always @(posedge sys_clk) begin
    if (srst || !pg) begin
      scl_d   <= 1'b1;
      sda_d   <= 1'b1;
      state   <= ST_IDLE;
      bit_cnt <= 4'h0;
      shift   <= 8'h00;
      rd_ptr  <= 3'h0;
      sda_out <= 1'b1;
      sda_oe  <= 1'b0;
      for (i = 0; i < 8; i = i + 1)
        regs[i] <= `DCS_REG_RESET;
    end else begin
      scl_d <= scl;
      sda_d <= sda;
      if (start_c) begin
        state   <= ST_ADDR;
        bit_cnt <= 4'h0;
        sda_oe  <= 1'b0;
      end else if (stop_c) begin
        state  <= ST_IDLE;
        sda_oe <= 1'b0;
      end else begin
        case (state)
          ST_IDLE: begin
            sda_oe <= 1'b0;
          end
          ST_ADDR, ST_WDAT: begin
            if (scl_rise) begin
              shift   <= {shift[6:0], sda};
              bit_cnt <= bit_cnt + 4'h1;
            end else if (scl_fall && bit_cnt == 4'h8) begin
              bit_cnt <= 4'h0;
              if (state == ST_ADDR) begin
                if (shift[7:2] == `DCS_ADDR_TOP) begin
                  state   <= ST_AACK;
                  sda_out <= 1'b0;
                  sda_oe  <= 1'b1;
                end else begin
                  state <= ST_IDLE;
                end
              end else begin
                // Writable bits only; select bits land in the target
                regs[wsel] <= (shift & wmask(wsel[1:0])) |
                              (regs[wsel] & ~wmask(wsel[1:0]));
                state   <= ST_WACK;
                sda_out <= 1'b0;
                sda_oe  <= 1'b1;
              end
            end
          end
          ST_AACK: begin
            if (scl_fall) begin
              if (shift[0]) begin
                state   <= ST_RDAT;
                rd_ptr  <= 3'h1;
                shift   <= {rd_word[0][6:0], 1'b0};
                sda_out <= rd_word[0][7];
                sda_oe  <= ~rd_word[0][7];
                bit_cnt <= 4'h1;
              end else begin
                state  <= ST_WDAT;
                sda_oe <= 1'b0;
              end
            end
          end
          ST_WACK: begin
            if (scl_fall) begin
              state  <= ST_WDAT;
              sda_oe <= 1'b0;
            end
          end
          ST_RDAT: begin
            // Open drain: only pull low, release for ones
            if (scl_fall) begin
              if (bit_cnt == 4'h8) begin
                state  <= ST_RACK;
                sda_oe <= 1'b0;
              end else begin
                sda_out <= shift[7];
                sda_oe  <= ~shift[7];
                shift   <= {shift[6:0], 1'b0};
                bit_cnt <= bit_cnt + 4'h1;
              end
            end
          end
          ST_RACK: begin
            if (scl_rise) begin
              if (sda) begin
                state <= ST_IDLE;
              end else begin
                state   <= ST_RDAT;
                shift   <= rd_word[rd_ptr];
                rd_ptr  <= rd_ptr + 3'h1;
                bit_cnt <= 4'h0;
              end
            end
          end
          default: state <= ST_IDLE;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Channel controls
  // ----------------------------------------------------------------
  wire [1:0] c_tone;
  wire [1:0] c_pass;
  wire [1:0] c_thr;
  wire [1:0] c_dyn;
  wire [5:0] c_lim;
  wire [1:0] c_pwr;
  wire [3:0] c_lvl;

  generate
    for (g = 0; g < 2; g = g + 1) begin : g_ch
      dcs_channel_ctrl u_ch (
        .sys_clk             (sys_clk),
        .srst                (srst),
        .tone_reg            (regs[4*g+1]),
        .limit_reg           (regs[4*g+2]),
        .output_reg          (regs[4*g+3]),
        .range_pin           (rng_s[g]),
        .modulation_in       (mod_s[g]),
        .tone_on             (c_tone[g]),
        .tone_passthrough    (c_pass[g]),
        .detect_tx_threshold (c_thr[g]),
        .dynamic_limit       (c_dyn[g]),
        .limit_code          (c_lim[3*g+2:3*g]),
        .power_enable        (c_pwr[g]),
        .level_code          (c_lvl[2*g+1:2*g])
      );
    end
  endgenerate

  // Top outputs straight from flops
  always @(posedge sys_clk) begin
    if (srst) begin
      tone_on             <= 2'h0;
      tone_passthrough    <= 2'h0;
      detect_tx_threshold <= 2'h0;
      dynamic_limit       <= 2'h0;
      limit_code          <= 6'h00;
      power_enable        <= 2'h0;
      level_code          <= 4'h0;
    end else begin
      tone_on             <= c_tone;
      tone_passthrough    <= c_pass;
      detect_tx_threshold <= c_thr;
      dynamic_limit       <= c_dyn;
      limit_code          <= c_lim;
      power_enable        <= c_pwr & {2{pg}};
      level_code          <= c_lvl;
    end
  end
endmodule
`default_nettype wire

// ===== design/dcs_consts.vh
// Notes on behaviour
// - Start, address byte, acked data bytes, stop
// - Address bit zero: one reads, zero writes
// - Answer only addresses matching 0001 00xx
// - Write mode updates any of eight registers
// - Top three data bits select the register, 000 to 011 channel one
// - Codes 100 to 111 select channel two
// - All register bits clear at power-on
// - Status select bits writable, flags read-only
// - Overcurrent flag reported from protection logic
// - Back-current flag reported from protection logic
// - Voltage-range flag reported from protection logic
// - Open-cable flag reported from protection logic
// - Over-temperature flag follows thermal shutdown state
// - Tone gate and source select steer tone
// - Threshold bit picks receive or transmit level
// - Range and select bits choose current threshold
// - Static-limit bit set disables dynamic limiting
// - Pin-select-disable bit ignores range pin
// - Power enable bit runs channel converter
// - Register steps choose output level directly
// - With pin enabled, pin picks range
// - Channel-two status bit four unused
// - Unused and read-only bits ignore writes
// - No acknowledge while power-good is low
// - Read bytes msb first; host nak ends
`ifndef DCS_CONSTS_VH
`define DCS_CONSTS_VH
`define DCS_ADDR_TOP      6'h04
`define DCS_SEL_MSB       7
`define DCS_SEL_LSB       5
`define DCS_REG_RESET     8'h00
`define DCS_STATUS_WMASK  8'he0
`define DCS_TONE_WMASK    8'hfc
`define DCS_LIMIT_WMASK   8'hff
`define DCS_OUTPUT_WMASK  8'hf3
`define DCS_SYNC_STAGES   3
`endif

// ===== design/dcs_pin_sync.v
`timescale 1ns/10ps
`default_nettype none
// ----------------------------------------------------------------
// Three-stage pin synchroniser, change taken when stages 2 and 3 agree
// ----------------------------------------------------------------
module dcs_pin_sync #(
  parameter WIDTH = 2
) (
  input  wire             sys_clk,
  input  wire             srst,
  input  wire [WIDTH-1:0] pin_in,
  output reg  [WIDTH-1:0] pin_out
);
  reg [WIDTH-1:0] stage1;
  reg [WIDTH-1:0] stage2;
  reg [WIDTH-1:0] stage3;

  // Idle bus is high, so reset to ones
  always @(posedge sys_clk) begin
    if (srst) begin
      stage1  <= {WIDTH{1'b1}};
      stage2  <= {WIDTH{1'b1}};
      stage3  <= {WIDTH{1'b1}};
      pin_out <= {WIDTH{1'b1}};
    end else begin
      stage1 <= pin_in;
      stage2 <= stage1;
      stage3 <= stage2;
      pin_out <= (stage2 & stage3) | (pin_out & (stage2 | stage3));
    end
  end
endmodule
`default_nettype wire

// ===== design/dcs_channel_ctrl.v
`timescale 1ns/10ps
`default_nettype none
`include "dcs_consts.vh"
// ----------------------------------------------------------------
// Per-channel decode of tone, limit and output-level controls
// ----------------------------------------------------------------
module dcs_channel_ctrl (
  input  wire       sys_clk,
  input  wire       srst,
  input  wire [7:0] tone_reg,
  input  wire [7:0] limit_reg,
  input  wire [7:0] output_reg,
  input  wire       range_pin,
  input  wire       modulation_in,
  output reg        tone_on,
  output reg        tone_passthrough,
  output reg        detect_tx_threshold,
  output reg        dynamic_limit,
  output reg  [2:0] limit_code,
  output reg        power_enable,
  output reg  [1:0] level_code
);
  wire gate      = tone_reg[4];
  wire src_sel   = tone_reg[3];
  wire pin_dis   = limit_reg[3];
  wire high_step = output_reg[1];
  wire low_step  = output_reg[0];

  // Registered so downstream analog sees glitch-free controls
  always @(posedge sys_clk) begin
    if (srst) begin
      tone_on             <= 1'b0;
      tone_passthrough    <= 1'b0;
      detect_tx_threshold <= 1'b0;
      dynamic_limit       <= 1'b0;
      limit_code          <= 3'h0;
      power_enable        <= 1'b0;
      level_code          <= 2'h0;
    end else begin
      tone_passthrough <= src_sel;
      tone_on <= src_sel ? modulation_in :
                 (gate ? 1'b1 : modulation_in);
      detect_tx_threshold <= tone_reg[2];
      dynamic_limit <= ~limit_reg[4];
      // Code 0 is 305mA, 4..7 are 388..890mA
      limit_code <= limit_reg[2] ? {1'b1, limit_reg[1:0]} : 3'h0;
      power_enable <= output_reg[4];
      if (pin_dis)
        level_code <= {high_step, low_step};
      else if (range_pin)
        level_code <= {1'b1, high_step};
      else
        level_code <= {1'b0, low_step};
    end
  end
endmodule
`default_nettype wire

// ===== verification/dcs_reg_bank_properties.sv
`timescale 1ns/10ps
`default_nettype none
// --------------------
// Bus pin and output checks
// --------------------
module dcs_reg_bank_properties (
  input wire logic       sys_clk,
  input wire logic       srst,
  input wire logic       scl_in,
  input wire logic       sda_out,
  input wire logic       sda_oe,
  input wire logic       power_good,
  input wire logic [5:0] limit_code,
  input wire logic [1:0] power_enable,
  input wire logic [3:0] level_code
);
  logic [7:0] run;
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (srst);
  // Drive length; a stuck driver hangs the whole bus
  always @(posedge sys_clk) begin
    if (srst || !sda_oe)
      run <= 8'h00;
    else if (run != 8'hff)
      run <= run + 8'h01;
  end
  // Supply bad long enough to cross the sync stages
  sequence s_pg_low;
    !power_good [*7];
  endsequence
  // Clock seen low before a drive starts
  sequence s_scl_low;
    !$past(scl_in, 1) && !$past(scl_in, 3);
  endsequence
  chk_no_ack_pg: assert property (s_pg_low |-> !sda_oe)
    else $error("drive while supply bad");
  chk_pe_pg: assert property (s_pg_low |-> !power_enable)
    else $error("enable while supply bad");
  chk_reset_clear: assert property ($past(srst) |-> !sda_oe
    && !power_enable && !level_code && !limit_code)
    else $error("outputs not clear after reset");
  chk_pull_low: assert property (sda_oe |-> !sda_out)
    else $error("pin driven high");
  chk_drive_start: assert property ($rose(sda_oe) |-> s_scl_low)
    else $error("drive began with clock high");
  chk_hold_high: assert property (sda_oe && scl_in |=> sda_oe)
    else $error("drive released with clock high");
  chk_limit_code: assert property ((limit_code[2] || !limit_code[1:0])
    && (limit_code[5] || !limit_code[4:3]))
    else $error("limit code out of set");
  chk_drive_len: assert property (run < 8'd100)
    else $error("drive held too long");
endmodule
bind dcs_reg_bank dcs_reg_bank_properties u_props (.sys_clk, .srst,
  .scl_in, .sda_out, .sda_oe, .power_good, .limit_code, .power_enable,
  .level_code);
`default_nettype wire

// ===== verification/dcs_host_model.sv
`timescale 1ns/10ps
`default_nettype none
// --------------------
// Bus host, 80 ns clock, still between frames
// --------------------
module dcs_host_model (
  input  wire logic sys_clk,
  input  wire logic sda_line,
  output var  logic scl,
  output var  logic sda_pull
);
  // Idle bus: both lines released high
  initial begin
    scl = 1'b1;
    sda_pull = 1'b0;
  end
  // Data moves only while the clock is low
  task automatic slot(input logic b, output logic r);
    sda_pull = !b;
    repeat (3) @(negedge sys_clk);
    scl = 1'b1;
    repeat (5) @(negedge sys_clk);
    r = sda_line;
    scl = 1'b0;
    repeat (2) @(negedge sys_clk);
  endtask
  task automatic start;
    sda_pull = 1'b1;
    repeat (5) @(negedge sys_clk);
    scl = 1'b0;
    repeat (2) @(negedge sys_clk);
  endtask
  task automatic stop;
    sda_pull = 1'b1;
    repeat (3) @(negedge sys_clk);
    scl = 1'b1;
    repeat (5) @(negedge sys_clk);
    sda_pull = 1'b0;
    repeat (5) @(negedge sys_clk);
  endtask
  // Byte msb first, then the answer slot; last=1 releases it
  task automatic xfer(input logic [7:0] d, input logic last,
                      output logic [7:0] q, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      slot(d[i], r);
      q[i] = r;
    end
    slot(last, r);
    ack = !r;
  endtask
endmodule
`default_nettype wire

// ===== verification/tb_dual_channel_supply_reg_bank.sv
`timescale 1ns/10ps
`default_nettype none
`include "dcs_consts.vh"
// --------------------
// Random writes, read-back and refusals
// --------------------
module tb_dual_channel_supply_reg_bank;
  logic       sys_clk = 1'b0;
  logic       srst, scl, sda_pull, sda_line, sda_out, sda_oe;
  logic       power_good, over_temp_in;
  logic [1:0] open_cable_in, voltage_range_in, overcurrent_in;
  logic [1:0] back_current_in, range_pin_in, modulation_in, tone_on;
  logic [1:0] tone_passthrough, detect_tx_threshold, dynamic_limit;
  logic [1:0] power_enable;
  logic [5:0] limit_code;
  logic [3:0] level_code;
  logic [7:0] sh [8];
  logic [7:0] d;
  int         n_errors = 0;
  int         cmp_count = 0;
  always #4 sys_clk = ~sys_clk;
  // Pull-up: low only while someone pulls
  assign sda_line = !(sda_pull || (sda_oe && !sda_out));
  dcs_host_model host (.sys_clk, .sda_line, .scl, .sda_pull);
  dcs_reg_bank dut (.sys_clk, .srst, .scl_in(scl), .sda_in(sda_line),
    .sda_out, .sda_oe, .power_good, .over_temp_in, .open_cable_in,
    .voltage_range_in, .overcurrent_in, .back_current_in, .range_pin_in,
    .modulation_in, .tone_on, .tone_passthrough, .detect_tx_threshold,
    .dynamic_limit, .limit_code, .power_enable, .level_code);
  task automatic check(input string what, input logic [11:0] e, g);
    cmp_count++;
    if (g !== e) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic close_out;
    $display("checks %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  function automatic logic [7:0] wmask(input logic [2:0] s);
    case (s[1:0])
      2'd0: return `DCS_STATUS_WMASK;
      2'd1: return `DCS_TONE_WMASK;
      2'd2: return `DCS_LIMIT_WMASK;
      default: return `DCS_OUTPUT_WMASK;
    endcase
  endfunction
  // Status bytes carry live flags; only channel one has the heat flag
  function automatic logic [7:0] exp_rd(input int i);
    if (i % 4 == 0)
      return {sh[i][7:5], i == 0 && over_temp_in, open_cable_in[i/4],
              voltage_range_in[i/4], overcurrent_in[i/4],
              back_current_in[i/4]};
    return sh[i];
  endfunction
  // Tone level is only defined with the internal source
  function automatic logic [9:0] exp_out(input int c);
    logic [7:0] t, l, o;
    logic       p;
    t = sh[4*c+1];
    l = sh[4*c+2];
    o = sh[4*c+3];
    p = range_pin_in[c];
    return {t[3] ? modulation_in[c] : (t[4] | modulation_in[c]),
            t[3], t[2], !l[4], l[2],
            l[2] & l[1], l[2] & l[0], o[4] & power_good,
            l[3] ? o[1:0] : {p, p ? o[1] : o[0]}};
  endfunction
  // Bounded wait for the pins to cross the sync stages
  task automatic check_out;
    logic [9:0] e, g;
    for (int c = 0; c < 2; c++) begin
      for (int k = 0; k < 40; k++) begin
        e = exp_out(c);
        g = {tone_on[c], tone_passthrough[c],
             detect_tx_threshold[c], dynamic_limit[c], limit_code[3*c+:3],
             power_enable[c], level_code[2*c+:2]};
        if (g === e)
          break;
        @(negedge sys_clk);
      end
      check("channel outputs", {2'b00, e}, {2'b00, g});
      if (g !== e)
        close_out();
    end
  endtask
  task automatic write_tr(input logic [7:0] adr, d0, d1, input logic ok);
    logic [7:0] q;
    logic       a;
    host.start();
    host.xfer(adr, 1'b1, q, a);
    check("address ack", {11'h000, ok}, {11'h000, a});
    if (a) begin
      host.xfer(d0, 1'b1, q, a);
      host.xfer(d1, 1'b1, q, a);
      check("data ack", 12'h001, {11'h000, a});
      sh[d0[7:5]] = d0 & wmask(d0[7:5]);
      sh[d1[7:5]] = d1 & wmask(d1[7:5]);
    end
    host.stop();
  endtask
  // Nine bytes so the wrap back to the first register shows
  task automatic read_all(input logic [7:0] adr);
    logic [7:0] q;
    logic       a;
    host.start();
    host.xfer(adr, 1'b1, q, a);
    check("read address ack", 12'h001, {11'h000, a});
    for (int i = 0; i < 9; i++) begin
      host.xfer(8'hff, i == 8, q, a);
      check("read byte", {4'h0, exp_rd(i % 8)}, {4'h0, q});
    end
    host.stop();
  endtask
  // Reset values, random traffic, refusals, then a brown-out
  initial begin
    srst = 1'b1;
    power_good = 1'b1;
    {over_temp_in, open_cable_in, voltage_range_in} = 5'h00;
    {overcurrent_in, back_current_in, range_pin_in, modulation_in} = 8'h00;
    foreach (sh[k])
      sh[k] = 8'h00;
    void'($urandom(58));
    repeat (3) @(negedge sys_clk);
    srst = 1'b0;
    repeat (6) @(negedge sys_clk);
    check_out();
    read_all(8'h11);
    for (int i = 0; i < 28; i++) begin
      {over_temp_in, open_cable_in, voltage_range_in} = 5'($urandom);
      {overcurrent_in, back_current_in} = 4'($urandom);
      {range_pin_in, modulation_in} = 4'($urandom);
      d = (i < 8) ? {i[2:0], 5'($urandom)} : 8'($urandom);
      write_tr(8'h10 | 8'($urandom & 2), d, 8'($urandom), 1'b1);
      check_out();
      if (i % 7 == 6)
        read_all(8'h11 | 8'($urandom & 2));
    end
    for (int k = 0; k < 4; k++)
      write_tr(8'h14 << k, 8'h70, 8'hf3, 1'b0);
    read_all(8'h13);
    power_good = 1'b0;
    write_tr(8'h10, 8'h70, 8'hf3, 1'b0);
    foreach (sh[k])
      sh[k] = 8'h00;
    power_good = 1'b1;
    repeat (4) @(negedge sys_clk);
    check_out();
    read_all(8'h11);
    close_out();
  end
endmodule
`default_nettype wire
